/* frame_coder_pkg.sv */
// Types for the DS3/E3 frame overhead coder
package frame_coder_pkg;
	typedef enum logic [1:0] {FMT_M13, FMT_CBIT, FMT_G751, FMT_G832} frame_fmt_t;
	typedef enum logic [1:0] {SYM_ZERO, SYM_MARK, SYM_B, SYM_V} line_sym_t;
endpackage : frame_coder_pkg

/* frame_coder_regs.svh */
// Constants for the DS3/E3 frame overhead coder
`ifndef FRAME_CODER_REGS_SVH
`define FRAME_CODER_REGS_SVH
`define DS3_FRAME_BITS 13'd4760
`define DS3_SUB_SPACING 13'd170
`define DS3_F_FIRST 13'd86
`define DS3_F_LAST 13'd4676
`define DS3_X1 13'd1
`define DS3_X2 13'd681
`define DS3_P1 13'd1361
`define DS3_P2 13'd2041
`define DS3_M1 13'd2721
`define DS3_M2 13'd3401
`define DS3_M3 13'd4081
`define DS3_C_FIRST 13'd171
`define DS3_C_LAST 13'd4591
`define DS3_STUFF_FIRST 13'd597
`define DS3_STUFF_SPACING 13'd681
`define DS3_STUFF_LAST 13'd4683
`define DS3_FEAC 13'd511
`define DS3_CP1 13'd1531
`define DS3_CP3 13'd1871
`define DS3_FEBE1 13'd2211
`define DS3_FEBE3 13'd2551
`define DS3_DL1 13'd2891
`define DS3_DL3 13'd3231
`define G751_FRAME_BITS 13'd1536
`define G751_FAS 10'h3D0
`define G751_FAS_LEN 13'd10
`define G751_ALARM 13'd11
`define G751_DL 13'd12
`define G751_J1 13'd385
`define G751_J2 13'd769
`define G751_J3 13'd1153
`define G751_STUFF 13'd1157
`define G832_FRAME_OCTETS 13'd537
`define G832_FA 16'hF628
`define G832_EM 13'd61
`define G832_TR 13'd121
`define G832_MA 13'd181
`define G832_NR 13'd241
`define G832_GC 13'd301
`define TRACE_LEN 4'hF
`endif

/* frame_overhead_coder.sv */
// DS3/E3 transmit framer that inserts overhead and feeds the line encoder
`timescale 1ns/1ps
`include "frame_coder_regs.svh"
module frame_overhead_coder
	import frame_coder_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire frame_fmt_t fmt_in,
	input wire logic rail_en_in,
	input wire logic bit_en_in,
	input wire logic payload_in,
	input wire logic remote_alarm_in,
	input wire logic feac_active_in,
	input wire logic feac_in,
	input wire logic febe_in,
	input wire logic dl_active_in,
	input wire logic dl_in,
	input wire logic [1:0] dl_octet_sel_in,
	input wire logic remote_error_in,
	input wire logic [2:0] payload_type_in,
	input wire logic [1:0] pd_mi_in,
	input wire logic timing_marker_in,
	input wire logic pass_path_parity_in,
	input wire logic path_parity_in,
	input wire logic just_in,
	input wire logic stuff_in,
	input wire logic [7:0] trace_octet_in,
	output logic [3:0] trace_idx_out,
	output logic payload_req_out,
	output logic frame_start_out,
	output logic line_pos_out,
	output logic line_neg_out,
	output logic line_nrz_out
);
	typedef struct packed {
		logic [12:0] pos;
		logic [2:0] bit_idx;
		logic parity;
		logic parity_prev;
		logic [7:0] bip;
		logic [7:0] bip_prev;
		logic [7:0] octet;
		logic [3:0] trace_idx;
		logic req;
		logic start;
		logic out_valid;
		logic out_bit;
	} framer_state_t;
	framer_state_t s_q, s_d;
	line_sym_if sym ();
	logic enc_pos, enc_neg, enc_nrz;
	logic ds3;
	logic [12:0] frame_len;
	logic ovh;
	logic ovh_bit;
	logic [12:0] sub_off;
	logic [12:0] c_off;

	assign ds3 = (fmt_in == FMT_M13) || (fmt_in == FMT_CBIT);

	function automatic logic in_range(input logic [12:0] p, input logic [12:0] lo,
		input logic [12:0] hi);
		in_range = (p >= lo) && (p <= hi);
	endfunction : in_range

	function automatic logic on_grid(input logic [12:0] p, input logic [12:0] first,
		input logic [12:0] last);
		on_grid = in_range(p, first, last) && ((p - first) % `DS3_SUB_SPACING == 13'd0);
	endfunction : on_grid

	// G.832 octet contents at a given octet position, in transmit order
	function automatic logic [7:0] g832_octet(input logic [12:0] p, input logic [7:0] bip,
		input logic [7:0] tr, input logic [7:0] ma, input logic [7:0] pl, input logic dl);
		if (p == 13'd1)
			g832_octet = 8'(`G832_FA >> 8);
		else if (p == 13'd2)
			g832_octet = 8'(`G832_FA);
		else if (p == `G832_EM)
			g832_octet = bip;
		else if (p == `G832_TR)
			g832_octet = tr;
		else if (p == `G832_MA)
			g832_octet = ma;
		else if (p == `G832_NR || p == `G832_GC)
			g832_octet = dl ? pl : 8'hFF;
		else
			g832_octet = pl;
	endfunction : g832_octet

	always_comb begin
		unique case (fmt_in)
			FMT_M13, FMT_CBIT: frame_len = `DS3_FRAME_BITS;
			FMT_G751: frame_len = `G751_FRAME_BITS;
			FMT_G832: frame_len = `G832_FRAME_OCTETS;
		endcase
	end

	assign sub_off = (s_q.pos - `DS3_F_FIRST) / `DS3_SUB_SPACING;
	assign c_off = (s_q.pos - `DS3_C_FIRST) / `DS3_SUB_SPACING;

	// Overhead decision for bit formats; payload positions leave ovh low
	always_comb begin
		ovh = 1'b0;
		ovh_bit = 1'b1;
		if (ds3) begin
			if (s_q.pos == `DS3_M1 || s_q.pos == `DS3_M3) begin
				ovh = 1'b1;
				ovh_bit = 1'b0;
			end else if (s_q.pos == `DS3_M2) begin
				ovh = 1'b1;
				ovh_bit = 1'b1;
			end else if (on_grid(s_q.pos, `DS3_F_FIRST, `DS3_F_LAST)) begin
				ovh = 1'b1;
				ovh_bit = (sub_off[1:0] == 2'd0) || (sub_off[1:0] == 2'd3);
			end else if (s_q.pos == `DS3_X1 || s_q.pos == `DS3_X2) begin
				ovh = 1'b1;
				ovh_bit = ~remote_alarm_in;
			end else if (s_q.pos == `DS3_P1 || s_q.pos == `DS3_P2) begin
				ovh = 1'b1;
				ovh_bit = s_q.parity_prev;
			end else if (on_grid(s_q.pos, `DS3_C_FIRST, `DS3_C_LAST)) begin
				ovh = 1'b1;
				if (fmt_in == FMT_M13)
					ovh_bit = just_in;
				else if (s_q.pos == `DS3_FEAC)
					ovh_bit = feac_active_in ? feac_in : 1'b1;
				else if (in_range(s_q.pos, `DS3_CP1, `DS3_CP3))
					ovh_bit = pass_path_parity_in ? path_parity_in : s_q.parity_prev;
				else if (in_range(s_q.pos, `DS3_FEBE1, `DS3_FEBE3))
					ovh_bit = ~febe_in;
				else if (in_range(s_q.pos, `DS3_DL1, `DS3_DL3))
					ovh_bit = dl_active_in ? dl_in : 1'b1;
				else
					ovh_bit = 1'b1;
			end else if (fmt_in == FMT_M13 && s_q.pos >= `DS3_STUFF_FIRST
				&& s_q.pos <= `DS3_STUFF_LAST
				&& (s_q.pos - `DS3_STUFF_FIRST) % `DS3_STUFF_SPACING == 13'd0) begin
				ovh = 1'b1;
				ovh_bit = stuff_in;
			end
			if (c_off > 13'd20)
				ovh_bit = ovh_bit;
		end else if (fmt_in == FMT_G751) begin
			if (in_range(s_q.pos, 13'd1, `G751_FAS_LEN)) begin
				ovh = 1'b1;
				ovh_bit = 1'(`G751_FAS >> (`G751_FAS_LEN - s_q.pos));
			end else if (s_q.pos == `G751_ALARM) begin
				ovh = 1'b1;
				ovh_bit = remote_alarm_in;
			end else if (s_q.pos == `G751_DL) begin
				ovh = 1'b1;
				ovh_bit = dl_active_in ? dl_in : 1'b1;
			end else if (in_range(s_q.pos, `G751_J1, `G751_J1 + 13'd3)
				|| in_range(s_q.pos, `G751_J2, `G751_J2 + 13'd3)
				|| in_range(s_q.pos, `G751_J3, `G751_J3 + 13'd3)) begin
				ovh = 1'b1;
				ovh_bit = just_in;
			end else if (in_range(s_q.pos, `G751_STUFF, `G751_STUFF + 13'd3)) begin
				ovh = 1'b1;
				ovh_bit = stuff_in;
			end
		end
	end

	logic g832_ovh;
	assign g832_ovh = s_q.pos == 13'd1 || s_q.pos == 13'd2 || s_q.pos == `G832_EM
		|| s_q.pos == `G832_TR || s_q.pos == `G832_MA
		|| ((s_q.pos == `G832_NR) && !(dl_active_in && dl_octet_sel_in[0]))
		|| ((s_q.pos == `G832_GC) && !(dl_active_in && dl_octet_sel_in[1]));

	always_comb begin
		logic [12:0] next_pos;
		logic last_unit;
		logic [7:0] ma;
		logic [7:0] oct;
		logic sel_dl;
		next_pos = 13'd0;
		last_unit = 1'b0;
		oct = 8'h00;
		ma = {remote_alarm_in, remote_error_in, payload_type_in, pd_mi_in,
			timing_marker_in};
		sel_dl = dl_active_in && ((s_q.pos == `G832_NR && dl_octet_sel_in[0])
			|| (s_q.pos == `G832_GC && dl_octet_sel_in[1]));
		s_d = s_q;
		s_d.req = 1'b0;
		s_d.start = 1'b0;
		s_d.out_valid = bit_en_in;
		if (bit_en_in) begin
			if (fmt_in == FMT_G832) begin
				// Each bit is taken straight from payload_in, or from the overhead octet at overhead positions
				oct = g832_octet(s_q.pos, s_q.bip_prev, trace_octet_in, ma,
					s_q.octet, sel_dl);
				s_d.out_bit = g832_ovh ? oct[3'd7 - s_q.bit_idx] : payload_in;
				s_d.req = ~g832_ovh;
				s_d.bip[3'd7 - s_q.bit_idx] = s_q.bip[3'd7 - s_q.bit_idx]
					^ s_d.out_bit;
				s_d.bit_idx = s_q.bit_idx + 3'd1;
				last_unit = (s_q.bit_idx == 3'd7) && (s_q.pos == frame_len);
				if (s_q.bit_idx == 3'd7) begin
					next_pos = s_q.pos + 13'd1;
					s_d.pos = last_unit ? 13'd1 : next_pos;
					if (s_q.pos == `G832_TR)
						s_d.trace_idx = s_q.trace_idx + 4'd1;
				end
			end else begin
				s_d.out_bit = ovh ? ovh_bit : payload_in;
				s_d.req = ~ovh;
				if (!ovh)
					s_d.parity = s_q.parity ^ payload_in;
				last_unit = s_q.pos == frame_len;
				s_d.pos = last_unit ? 13'd1 : s_q.pos + 13'd1;
			end
			if (last_unit) begin
				s_d.parity_prev = s_d.parity;
				s_d.parity = 1'b0;
				s_d.bip_prev = s_d.bip;
				s_d.bip = 8'h00;
				s_d.start = 1'b1;
			end
		end
		if (reset_in) begin
			s_d = '0;
			s_d.pos = 13'd1;
		end
	end

	always_ff @(posedge mclk_in) begin
		s_q <= s_d;
	end

	assign sym.valid = s_q.out_valid;
	assign sym.data = s_q.out_bit;
	assign sym.rail_en = rail_en_in;
	assign sym.ds3 = ds3;

	zero_sub_encoder u_enc (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.sym(sym),
		.pos_q(enc_pos),
		.neg_q(enc_neg),
		.nrz_q(enc_nrz)
	);

	assign line_pos_out = enc_pos;
	assign line_neg_out = enc_neg;
	assign line_nrz_out = enc_nrz;
	assign trace_idx_out = s_q.trace_idx;
	assign payload_req_out = s_q.req;
	assign frame_start_out = s_q.start;

	AST_DS3_WRAP: assert property (@(posedge mclk_in) disable iff (reset_in)
		ds3 && bit_en_in && s_q.pos == `DS3_FRAME_BITS |=> s_q.pos == 13'd1)
		else $error("DS3 frame did not wrap at 4760");
	AST_M_ZERO: assert property (@(posedge mclk_in) disable iff (reset_in)
		ds3 && bit_en_in && s_q.pos == `DS3_M1 |=> !s_q.out_bit)
		else $error("first M bit not zero");
	AST_F_ONE: assert property (@(posedge mclk_in) disable iff (reset_in)
		ds3 && bit_en_in && s_q.pos == `DS3_F_FIRST |=> s_q.out_bit)
		else $error("first F bit not one");
	AST_X_BIT: assert property (@(posedge mclk_in) disable iff (reset_in)
		ds3 && bit_en_in && s_q.pos == `DS3_X2 |=> s_q.out_bit == !$past(remote_alarm_in))
		else $error("X bit wrong");
	AST_P_BIT: assert property (@(posedge mclk_in) disable iff (reset_in)
		ds3 && bit_en_in && s_q.pos == `DS3_P1 |=> s_q.out_bit == $past(s_q.parity_prev))
		else $error("P bit wrong");
	AST_FEAC_IDLE: assert property (@(posedge mclk_in) disable iff (reset_in)
		fmt_in == FMT_CBIT && bit_en_in && s_q.pos == `DS3_FEAC && !feac_active_in
		|=> s_q.out_bit) else $error("idle FEAC not one");
	AST_G751_FAS: assert property (@(posedge mclk_in) disable iff (reset_in)
		fmt_in == FMT_G751 && bit_en_in && s_q.pos == 13'd5 |=> !s_q.out_bit)
		else $error("FAS bit 5 wrong");
	AST_G832_START: assert property (@(posedge mclk_in) disable iff (reset_in)
		fmt_in == FMT_G832 && bit_en_in && s_q.pos == 13'd1 && s_q.bit_idx == 3'd0
		|=> s_q.out_bit && s_q.start == 1'b0) else $error("FA first bit wrong");
endmodule : frame_overhead_coder

/* line_sym_if.sv */
// Symbol stream between the framer and the zero-substitution encoder
`timescale 1ns/1ps
interface line_sym_if;
	logic valid;
	logic data;
	logic rail_en;
	logic ds3;
	modport src (output valid, output data, output rail_en, output ds3);
	modport dst (input valid, input data, input rail_en, input ds3);
endinterface : line_sym_if

/* line_unit_model.sv */
// Line interface unit model: paces the framer and checks the bipolar line code
`timescale 1ns/1ps
module line_unit_model (
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic slow_in,
	input wire logic check_in,
	input wire logic ds3_in,
	input wire logic pos_in,
	input wire logic neg_in,
	output logic bit_en_out,
	output logic [15:0] fault_out,
	output logic [15:0] viol_out
);
	logic [1:0] phase_q;
	logic [2:0] zeros_q;
	logic last_q;
	logic have_q;
	logic vpol_q;
	logic havev_q;
	// Slow mode leaves two idle cycles between line bits
	assign bit_en_out = !reset_in && (!slow_in || phase_q == 2'h0);
	always @(posedge mclk_in) begin
		phase_q <= (reset_in || phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
		if (reset_in) begin
			fault_out <= 16'h0;
			viol_out <= 16'h0;
		end
		if (!check_in) begin
			zeros_q <= 3'h0;
			have_q <= 1'h0;
			havev_q <= 1'h0;
		end else if (bit_en_out) begin
			if (pos_in && neg_in)
				fault_out <= fault_out + 16'h1;
			if (!pos_in && !neg_in) begin
				zeros_q <= zeros_q + 3'h1;
				if (zeros_q >= (ds3_in ? 3'h2 : 3'h3))
					fault_out <= fault_out + 16'h1;
			end else begin
				zeros_q <= 3'h0;
				last_q <= pos_in;
				have_q <= 1'h1;
				if (have_q && last_q == pos_in) begin
					viol_out <= viol_out + 16'h1;
					vpol_q <= pos_in;
					havev_q <= 1'h1;
					// An odd pulse count between violations makes them alternate
					if (havev_q && vpol_q == pos_in)
						fault_out <= fault_out + 16'h1;
				end
			end
		end
	end
endmodule : line_unit_model

/* tb_ds3_e3_frame_overhead_coder.sv */
// Self-checking bench for the DS3/E3 frame overhead coder
`timescale 1ns/1ps
module tb_ds3_e3_frame_overhead_coder import frame_coder_pkg::*;;
	typedef struct {frame_fmt_t fmt; bit hot; int pos; int len; logic [15:0] pat;} row_t;
	row_t rows [34] = '{
		'{FMT_G751, 0, 1, 10, 16'h03D0}, '{FMT_G751, 0, 11, 1, 16'h0},
		'{FMT_G751, 0, 12, 1, 16'h1}, '{FMT_G751, 0, 385, 4, 16'h0},
		'{FMT_G751, 0, 769, 4, 16'h0}, '{FMT_G751, 1, 11, 1, 16'h1},
		'{FMT_G751, 1, 12, 1, 16'h0}, '{FMT_G751, 1, 1153, 4, 16'hF},
		'{FMT_CBIT, 0, 1, 1, 16'h1}, '{FMT_CBIT, 0, 681, 1, 16'h1},
		'{FMT_CBIT, 0, 2721, 1, 16'h0}, '{FMT_CBIT, 0, 3401, 1, 16'h1},
		'{FMT_CBIT, 0, 4081, 1, 16'h0}, '{FMT_CBIT, 0, 86, 1, 16'h1},
		'{FMT_CBIT, 0, 256, 1, 16'h0}, '{FMT_CBIT, 0, 596, 1, 16'h1},
		'{FMT_CBIT, 0, 171, 1, 16'h1}, '{FMT_CBIT, 0, 341, 1, 16'h1},
		'{FMT_CBIT, 0, 511, 1, 16'h1}, '{FMT_CBIT, 0, 851, 1, 16'h1},
		'{FMT_CBIT, 0, 4251, 1, 16'h1}, '{FMT_CBIT, 0, 2211, 1, 16'h1},
		'{FMT_CBIT, 0, 2891, 1, 16'h1}, '{FMT_CBIT, 1, 1, 1, 16'h0},
		'{FMT_CBIT, 1, 681, 1, 16'h0}, '{FMT_CBIT, 1, 511, 1, 16'h0},
		'{FMT_CBIT, 1, 3231, 1, 16'h0}, '{FMT_M13, 1, 171, 1, 16'h1},
		'{FMT_M13, 1, 4591, 1, 16'h1}, '{FMT_G832, 0, 1, 16, 16'hF628},
		'{FMT_G832, 0, 961, 4, 16'hA}, '{FMT_G832, 0, 1441, 8, 16'h2C},
		'{FMT_G832, 0, 1921, 8, 16'hFF}, '{FMT_G832, 1, 1441, 8, 16'hD3}};
	frame_fmt_t rf [3] = '{FMT_CBIT, FMT_G751, FMT_G832};
	int pp [5] = '{1361, 2041, 1531, 1701, 1871};
	logic mclk_in, reset_in, rail, hot, pay_on, payload, bit_en, slow, check_en;
	frame_fmt_t fmt;
	logic [3:0] trace_idx;
	logic req, fs, lpos, lneg, lnrz, pl_prev, par, fpar, par_a, bip;
	logic [15:0] fault, viol, t0, t1;
	logic [7:0] cyc;
	logic cb [0:8599];
	int pc, pcnt, mismatches, samples_checked, lag, found;
	row_t r;
	frame_overhead_coder dut (.mclk_in(mclk_in), .reset_in(reset_in), .fmt_in(fmt),
		.rail_en_in(rail), .bit_en_in(bit_en), .payload_in(payload), .remote_alarm_in(hot),
		.feac_active_in(hot), .feac_in(1'h0), .febe_in(1'h0), .dl_active_in(hot), .dl_in(1'h0),
		.dl_octet_sel_in(hot ? 2'h3 : 2'h1), .remote_error_in(hot),
		.payload_type_in(hot ? 3'h2 : 3'h5), .pd_mi_in(hot ? 2'h1 : 2'h2),
		.timing_marker_in(hot), .pass_path_parity_in(hot), .path_parity_in(1'h0),
		.just_in(hot), .stuff_in(hot), .trace_octet_in({4'hA, trace_idx}),
		.trace_idx_out(trace_idx), .payload_req_out(req), .frame_start_out(fs),
		.line_pos_out(lpos), .line_neg_out(lneg), .line_nrz_out(lnrz));
	line_unit_model liu (.mclk_in(mclk_in), .reset_in(reset_in), .slow_in(slow),
		.check_in(check_en), .ds3_in(fmt == FMT_M13 || fmt == FMT_CBIT), .pos_in(lpos),
		.neg_in(lneg), .bit_en_out(bit_en), .fault_out(fault), .viol_out(viol));
	initial begin
		mclk_in = 1'h0;
		forever #10 mclk_in = ~mclk_in;
	end
	// Parity and payload count of each frame, from the bits the framer consumed
	always @(posedge mclk_in) begin
		cyc <= cyc + 8'h1;
		payload <= pay_on & (cyc[0] ^ cyc[2]);
		if (bit_en)
			pl_prev <= payload;
		if (reset_in) begin
			par <= 1'h0;
			pc <= 0;
		end else if (fs) begin
			fpar <= par ^ (req & pl_prev);
			pcnt <= pc + int'(req);
			par <= 1'h0;
			pc <= 0;
		end else if (req) begin
			par <= par ^ pl_prev;
			pc <= pc + 1;
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		samples_checked++;
		if (seen !== want) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check
	function automatic int flen(frame_fmt_t f);
		return (f == FMT_G751) ? 1536 : (f == FMT_G832) ? 4296 : 4760;
	endfunction : flen
	function automatic int plen(frame_fmt_t f);
		return (f == FMT_G751) ? 1508 : (f == FMT_G832) ? 4240 : (f == FMT_CBIT) ? 4704 : 4697;
	endfunction : plen
	function automatic logic [15:0] field(int p, int n);
		logic [15:0] v;
		v = 16'h0;
		for (int i = 0; i < n; i++)
			v = {v[14:0], cb[p - 1 + lag + i]};
		return v;
	endfunction : field
	task automatic wait_start();
		int k;
		for (k = 0; k < 20000 && fs !== 1'h1; k++) begin
			@(posedge mclk_in);
			#1;
		end
		check({15'h0, fs}, 16'h1);
		if (k >= 20000)
			complete_run();
	endtask : wait_start
	// Every change of format goes through reset, so it also exercises a reset in mid-run
	task automatic set_cfg(frame_fmt_t f, bit h, bit rl, bit p);
		int n;
		@(posedge mclk_in);
		reset_in <= 1'h1;
		fmt <= f;
		hot <= h;
		rail <= rl;
		pay_on <= p;
		repeat (2) @(posedge mclk_in);
		#1;
		check({7'h0, trace_idx, req, fs, lpos, lneg, lnrz}, 16'h0);
		@(posedge mclk_in);
		reset_in <= 1'h0;
		n = 0;
		do begin
			@(posedge mclk_in);
			#1;
			n++;
		end while (fs !== 1'h1 && n < 9000);
		check(16'(n), 16'(flen(f)));
		if (n >= 9000)
			complete_run();
	endtask : set_cfg
	task automatic grab(int n);
		@(posedge mclk_in);
		#1;
		par_a = fpar;
		for (int i = 0; i < n; i++) begin
			cb[i] = lnrz;
			@(posedge mclk_in);
			#1;
		end
	endtask : grab
	initial begin
		reset_in = 1'h1;
		fmt = FMT_G751;
		{rail, hot, pay_on, payload, slow, check_en, cyc} = 14'h0;
		mismatches = 0;
		samples_checked = 0;
		lag = -1;
		found = 0;
		repeat (4) @(posedge mclk_in);
		for (int k = 0; k < 34; k++) begin
			r = rows[k];
			if (k == 0 || r.fmt != rows[k - 1].fmt || r.hot != rows[k - 1].hot) begin
				set_cfg(r.fmt, r.hot, 1'h0, 1'h1);
				grab((r.fmt == FMT_G832 ? 2 : 1) * flen(r.fmt) + 8);
				// Output delay is not fixed by the hand-over, so it is found on the alignment word
				if (lag < 0) begin
					for (int l = 7; l >= 0; l--) begin
						lag = l;
						if (field(1, 10) === 16'h03D0)
							found = l;
					end
					lag = found;
				end
				for (int i = 0; i < 5; i++)
					if (r.fmt <= FMT_CBIT && (i < 2 || r.fmt == FMT_CBIT))
						check(field(pp[i], 1), {15'h0, (i > 1 && r.hot) ? 1'h0 : par_a});
				check(16'(pcnt), 16'(plen(r.fmt) + ((r.fmt == FMT_G832 && r.hot) ? 16 : 0)));
				if (r.fmt == FMT_G832) begin
					for (int b = 0; b < 8; b++) begin
						bip = 1'h0;
						for (int o = 0; o < 537; o++)
							bip ^= cb[lag + o * 8 + b];
						check({15'h0, cb[lag + 4776 + b]}, {15'h0, bip});
					end
					t0 = field(961, 8);
					t1 = field(5257, 8);
					check({12'h0, t1[3:0]}, {12'h0, t0[3:0] + 4'h1});
				end
			end
			check(field(r.pos, r.len), r.pat);
		end
		for (int i = 0; i < 3; i++) begin
			set_cfg(rf[i], 1'h0, 1'h1, 1'h0);
			@(posedge mclk_in);
			check_en <= 1'h1;
			slow <= (i == 1);
			@(posedge mclk_in);
			#1;
			wait_start();
			@(posedge mclk_in);
			check_en <= 1'h0;
			slow <= 1'h0;
			check(fault, 16'h0);
			check({15'h0, viol != 16'h0}, 16'h1);
		end
		complete_run();
	end
endmodule : tb_ds3_e3_frame_overhead_coder

/* zero_sub_encoder.sv */
// B3ZS/HDB3 zero substitution and AMI encoding of the outgoing bit stream
`timescale 1ns/1ps
module zero_sub_encoder
	import frame_coder_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	line_sym_if.dst sym,
	output logic pos_q,
	output logic neg_q,
	output logic nrz_q
);
	// Four-bit delay lets a later V rewrite the B slot already queued
	typedef struct packed {
		logic [3:0] dat;
		line_sym_t [3:0] kind;
		logic [2:0] zrun;
		logic last_pol;
		logic odd_b;
		logic pos;
		logic neg;
		logic nrz;
	} enc_state_t;
	enc_state_t s_q, s_d;
	logic [2:0] run_len;
	// Pulse parity since the last V, counting symbols still queued ahead of the run
	logic pend_odd;
	assign run_len = sym.ds3 ? 3'd3 : 3'd4;

	always_comb begin
		s_d = s_q;
		pend_odd = 1'b0;
		if (sym.valid) begin
			s_d.nrz = s_q.dat[3];
			s_d.pos = 1'b0;
			s_d.neg = 1'b0;
			unique case (s_q.kind[3])
				SYM_MARK, SYM_B: begin
					s_d.pos = ~s_q.last_pol;
					s_d.neg = s_q.last_pol;
					s_d.last_pol = ~s_q.last_pol;
					s_d.odd_b = ~s_q.odd_b;
				end
				SYM_V: begin
					s_d.pos = s_q.last_pol;
					s_d.neg = ~s_q.last_pol;
					s_d.odd_b = 1'b0;
				end
				SYM_ZERO: ;
			endcase
			if (!sym.rail_en) begin
				s_d.pos = s_q.dat[3];
				s_d.neg = 1'b0;
			end
			s_d.dat = {s_q.dat[2:0], sym.data};
			s_d.kind = {s_q.kind[2:0], sym.data ? SYM_MARK : SYM_ZERO};
			s_d.zrun = sym.data ? 3'd0 : s_q.zrun + 3'd1;
			if (!sym.data && sym.rail_en && s_q.zrun + 3'd1 == run_len) begin
				// Marks counted so far plus pending ones set the B decision
				s_d.zrun = 3'd0;
				s_d.kind[0] = SYM_V;
				pend_odd = s_d.odd_b;
				if (sym.ds3) begin
					if (s_q.kind[2] == SYM_V)
						pend_odd = 1'b0;
					else if (s_q.kind[2] != SYM_ZERO)
						pend_odd = ~pend_odd;
				end
				if (pend_odd == 1'b0) begin
					if (sym.ds3)
						s_d.kind[2] = SYM_B;
					else
						s_d.kind[3] = SYM_B;
				end
			end
		end
		if (reset_in)
			s_d = '0;
	end

	always_ff @(posedge mclk_in) begin
		s_q <= s_d;
	end

	assign pos_q = s_q.pos;
	assign neg_q = s_q.neg;
	assign nrz_q = s_q.nrz;

	AST_NO_DOUBLE_RAIL: assert property (@(posedge mclk_in) disable iff (reset_in)
		!(s_q.pos && s_q.neg)) else $error("both rails high");
endmodule : zero_sub_encoder
